// *** ssu_pkg.sv ***
/*
 * Constants for the simple serial unit: register offsets, bit positions,
 * reset values and clock divider counts.
 * Assumes a byte-wide processor port with one-cycle strobes.
 */
package ssu_pkg;
   // Register offsets on the processor port
   localparam logic [1:0] SSU_ADDR_CTRL   = 2'h0;
   localparam logic [1:0] SSU_ADDR_STATUS = 2'h1;
   localparam logic [1:0] SSU_ADDR_DATA   = 2'h2;
   // Control register field positions
   localparam int SSU_CTRL_IRQ_EN   = 7;
   localparam int SSU_CTRL_ENABLE   = 6;
   localparam int SSU_CTRL_LSB      = 5;
   localparam int SSU_CTRL_MASTER   = 4;
   localparam int SSU_CTRL_RATE     = 0;
   localparam logic [7:0] SSU_CTRL_WMASK = 8'hf1;
   localparam logic [7:0] SSU_CTRL_RESET = 8'h00;
   // Status register field positions
   localparam int SSU_STAT_DONE     = 7;
   localparam int SSU_STAT_COLL     = 6;
   // Master clock: half-period counts of the processor clock (div 2 and div 16)
   localparam int SSU_DIV_FAST      = 2;
   localparam int SSU_DIV_SLOW      = 16;
   localparam logic [2:0] SSU_HALF_FAST = 3'(SSU_DIV_FAST / 2 - 1);
   localparam logic [2:0] SSU_HALF_SLOW = 3'(SSU_DIV_SLOW / 2 - 1);
   localparam logic [2:0] SSU_LAST_BIT  = 3'h7;
   localparam logic [7:0] SSU_ZERO_BYTE = 8'h00;
   // Port C pin positions taken over by the serial unit
   localparam int SSU_PIN_IN        = 0;
   localparam int SSU_PIN_OUT       = 1;
   localparam int SSU_PIN_SCK       = 2;
   // Transfer states
   typedef enum logic [2:0] {
      SSU_IDLE = 3'b001,
      SSU_LOW  = 3'b010,
      SSU_HIGH = 3'b100
   } ssu_state_t;
endpackage : ssu_pkg

// *** ssu_rate_div.sv ***
/*
 * Divider for the master serial clock: one-cycle enable pulse at each
 * half period of the serial clock, by 2 or by 16 of the processor clock.
 * Assumes run is low whenever no master transfer is active.
 */
`timescale 1ns/1ps
module ssu_rate_div (
   input  wire logic clk,         // Processor clock
   input  wire logic rst_n,       // Asynchronous reset, active low
   input  wire logic run,         // Count while high
   input  wire logic slow,        // High selects divide by 16
   output logic      half_tick    // Pulse at each half period
);
   logic [2:0] count;
   logic [2:0] limit;

   // Limit of one half period
   assign limit     = slow ? ssu_pkg::SSU_HALF_SLOW : ssu_pkg::SSU_HALF_FAST;
   assign half_tick = run && (count == limit);

   // Half-period counter, restarts when idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 3'h0;
      end else if (!run || half_tick) begin
         count <= 3'h0;
      end else begin
         count <= count + 3'h1;
      end
   end
endmodule : ssu_rate_div

// *** ssu_serial_unit.sv ***
/*
 * Simple serial unit: three-wire full-duplex byte exchange, master or slave,
 * with control, status and shift data registers on a plain processor port.
 * Assumes all inputs synchronous to clk; the serial clock pin in slave mode
 * is sampled and its edges found in the clk domain.
 */
// What this block does
// - Enable hands port C bits 0-2 to data in, data out, serial clock.
// - Serial clock pin drives in master mode, is input in slave mode.
// - Bit-order select set shifts LSB first, clear shifts MSB first.
// - Bit-order select also sets how the processor bus maps to the shifter.
// - In master mode a data write starts the clock and the transfer.
// - Master serial clock, bit counter and shifter run from the processor clock.
// - Incoming byte shifts into the same register as outgoing byte leaves.
// - After eight bits the clock stops, done flag sets, interrupt if enabled.
// - Data writes are ignored while the done flag is set, except the one that completes the clearing sequence.
// - A stopped slave wakes on the completion interrupt; slave only.
// - In slave mode the pin clock shifts and the rate select is ignored.
// - A 3-bit bit counter overflows to set the done flag.
// - New output bit on falling clock edge, input sampled on rising edge.
// - Received byte replaces sent byte; one completion flag reports the end.
// - One byte is exchanged over exactly eight clock pulses.
// - Master rate: processor clock divided by 2, or by 16 when set.
// - Status access with done set, then data access, clears both flags.
// - Data access mid-transfer sets the collision flag, no interrupt.
`timescale 1ns/1ps
module ssu_serial_unit (
   input  wire logic       clk,            // Processor clock, 40 MHz
   input  wire logic       rst_n,          // Asynchronous reset, active low
   input  wire logic [1:0] addr,           // Register address
   input  wire logic [7:0] wdata,          // Write data
   input  wire logic       wr,             // Write strobe
   input  wire logic       rd,             // Read strobe
   output logic      [7:0] rdata,          // Read data, cycle after rd
   input  wire logic       stop_mode,      // Processor is in stop mode
   output logic            irq,            // Completion interrupt request
   output logic            wake,           // Wake from stop, slave only
   input  wire logic [2:0] port_c_out,     // Port C general data for bits 0-2
   input  wire logic [2:0] port_c_dir,     // Port C direction for bits 0-2
   input  wire logic [2:0] port_c_in,      // Port C pin levels 0-2
   output logic      [2:0] port_c_o,       // Port C pin outputs 0-2
   output logic      [2:0] port_c_oe       // Port C pin output enables 0-2
);
   // Control register and its fields
   logic [7:0]          ctrl;           // Control register
   logic                irq_en;         // Completion interrupt enable
   logic                enable;         // Serial port enable
   logic                lsb_first;      // Bit-order select
   logic                master;         // Master select
   logic                rate_slow;      // Rate select, divide by 16
   // Status flags and the clearing sequence
   logic                done;           // Transfer-complete flag
   logic                coll;           // Collision flag
   logic                clear_armed;    // Status seen with done set
   logic [7:0]          stat_word;      // Status register image
   // Shifter, bit counter and pin drivers
   logic [7:0]          shifter;        // Shift data register
   logic [7:0]          bus_to_shift;   // Write data in shift order
   logic [7:0]          shift_to_bus;   // Shifter in bus order
   logic [2:0]          bit_cnt;        // Bits taken in this byte
   logic                out_bit;        // Serial output latch
   logic                sck_out;        // Master serial clock
   logic                sck_pin;        // Serial clock pin level
   logic                sck_prev;       // Pin level one cycle ago
   logic                slave_active;   // Slave byte under way
   // Transfer sequencing
   ssu_pkg::ssu_state_t state;          // Master clock state
   ssu_pkg::ssu_state_t next_state;     // Next master clock state
   logic                run;            // Divider runs
   logic                half_tick;      // Half period elapsed
   logic                m_rise;         // Master rising clock edge
   logic                m_fall;         // Master falling clock edge
   logic                s_rise;         // Slave rising pin edge
   logic                s_fall;         // Slave falling pin edge
   logic                shift_in;       // Sample the input bit
   logic                shift_out;      // Present the next output bit
   logic                last_rise;      // Eighth rising edge
   logic                busy;           // Byte under way
   // Decoded processor accesses
   logic                ctrl_wr;        // Control write
   logic                stat_acc;       // Status read or write
   logic                data_wr;        // Data write
   logic                data_rd;        // Data read
   logic                data_acc;       // Data read or write
   logic                write_ok;       // Data write accepted
   logic                start;          // Master transfer start

   // Reverses a byte when LSB-first order is selected; used on both bus directions
   function automatic logic [7:0] map_order(input logic [7:0] value, input logic lsb);
      logic [7:0] result;
      result = value;
      if (lsb) begin
         for (int i = 0; i < $bits(value); i++) begin
            result[i] = value[$bits(value) - 1 - i];
         end
      end
      return result;
   endfunction : map_order

   // One strobe aimed at one register
   function automatic logic hit(input logic [1:0] a, input logic [1:0] target, input logic strobe);
      return strobe && (a == target);
   endfunction : hit

   // Access decode
   assign ctrl_wr  = hit(addr, ssu_pkg::SSU_ADDR_CTRL, wr);
   assign stat_acc = hit(addr, ssu_pkg::SSU_ADDR_STATUS, wr) || hit(addr, ssu_pkg::SSU_ADDR_STATUS, rd);
   assign data_wr  = hit(addr, ssu_pkg::SSU_ADDR_DATA, wr);
   assign data_rd  = hit(addr, ssu_pkg::SSU_ADDR_DATA, rd);
   assign data_acc = data_wr || data_rd;

   // Control fields
   assign irq_en    = ctrl[ssu_pkg::SSU_CTRL_IRQ_EN];
   assign enable    = ctrl[ssu_pkg::SSU_CTRL_ENABLE];
   assign lsb_first = ctrl[ssu_pkg::SSU_CTRL_LSB];
   assign master    = ctrl[ssu_pkg::SSU_CTRL_MASTER];
   assign rate_slow = ctrl[ssu_pkg::SSU_CTRL_RATE];

   // Bus to shifter mapping follows the bit order; the shifter itself is always MSB first
   assign bus_to_shift = map_order(wdata, lsb_first);
   assign shift_to_bus = map_order(shifter, lsb_first);

   // Transfer bookkeeping
   assign busy     = (state != ssu_pkg::SSU_IDLE) || slave_active;
   assign write_ok = data_wr && !busy && (!done || clear_armed);
   assign start    = write_ok && enable && master;
   assign run      = enable && master && (state != ssu_pkg::SSU_IDLE);

   // Master clock divider, processor clock by 2 or 16; unused in slave mode
   ssu_rate_div ssu_rate_div_inst (
      .clk       (clk),
      .rst_n     (rst_n),
      .run       (run),
      .slow      (rate_slow),
      .half_tick (half_tick)
   );

   // Clock edges: master from the divider, slave from the pin
   assign sck_pin   = port_c_in[ssu_pkg::SSU_PIN_SCK];
   assign m_rise    = (state == ssu_pkg::SSU_LOW) && half_tick;
   assign m_fall    = (state == ssu_pkg::SSU_HIGH) && half_tick;
   assign s_fall    = enable && !master && !done && sck_prev && !sck_pin;
   assign s_rise    = enable && !master && slave_active && !sck_prev && sck_pin;
   assign shift_in  = m_rise || s_rise;
   assign shift_out = m_fall || s_fall;
   assign last_rise = shift_in && (bit_cnt == ssu_pkg::SSU_LAST_BIT);

   // Master clock sequence: low and high halves, back to idle after the eighth rise
   always_comb begin
      next_state = state;
      case (state)
         ssu_pkg::SSU_IDLE: begin
            if (start) begin
               next_state = ssu_pkg::SSU_LOW;
            end
         end
         ssu_pkg::SSU_LOW: begin
            if (half_tick) begin
               next_state = last_rise ? ssu_pkg::SSU_IDLE : ssu_pkg::SSU_HIGH;
            end
         end
         ssu_pkg::SSU_HIGH: begin
            if (half_tick) begin
               next_state = ssu_pkg::SSU_LOW;
            end
         end
         default: begin
            next_state = ssu_pkg::SSU_IDLE;
         end
      endcase
      if (!enable || !master) begin
         next_state = ssu_pkg::SSU_IDLE;
      end
   end

   // Master state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ssu_pkg::SSU_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Master serial clock, high whenever no byte is under way
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_out <= 1'b1;
      end else if (!enable || !master) begin
         sck_out <= 1'b1;
      end else if (start || m_fall) begin
         sck_out <= 1'b0;
      end else if (m_rise) begin
         sck_out <= 1'b1;
      end
   end

   // Three-bit bit counter; its wrap marks the end of the byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= 3'h0;
      end else if (!enable || start) begin
         bit_cnt <= 3'h0;
      end else if (shift_in) begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   // Shift register: loaded by the processor, takes one input bit per rising edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shifter <= ssu_pkg::SSU_ZERO_BYTE;
      end else if (write_ok) begin
         shifter <= bus_to_shift;
      end else if (shift_in) begin
         shifter <= {shifter[$bits(shifter) - 2:0], port_c_in[ssu_pkg::SSU_PIN_IN]};
      end
   end

   // Output latch: next bit appears on each falling edge, the start counts as one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_bit <= 1'b1;
      end else if (start) begin
         out_bit <= bus_to_shift[$bits(bus_to_shift) - 1];
      end else if (shift_out) begin
         out_bit <= shifter[$bits(shifter) - 1];
      end
   end

   // Slave byte tracking: first falling pin edge opens it, eighth rise closes it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slave_active <= 1'b0;
      end else if (!enable || master || last_rise) begin
         slave_active <= 1'b0;
      end else if (s_fall) begin
         slave_active <= 1'b1;
      end
   end

   // Pin history for slave edges; idles high so no false edge follows reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev <= 1'b1;
      end else begin
         sck_prev <= enable ? sck_pin : 1'b1;
      end
   end

   // Control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= ssu_pkg::SSU_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl <= wdata & ssu_pkg::SSU_CTRL_WMASK;
      end
   end

   // Completion flag; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else if (last_rise) begin
         done <= 1'b1;
      end else if (data_acc && clear_armed) begin
         done <= 1'b0;
      end
   end

   // Collision flag: data access mid-byte, the byte itself goes on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coll <= 1'b0;
      end else if (data_acc && busy) begin
         coll <= 1'b1;
      end else if (data_acc && clear_armed) begin
         coll <= 1'b0;
      end
   end

   // First step of the clearing sequence: status touched while done is set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clear_armed <= 1'b0;
      end else if (stat_acc && done) begin
         clear_armed <= 1'b1;
      end else if (data_acc || !done) begin
         clear_armed <= 1'b0;
      end
   end

   // Status image
   always_comb begin
      stat_word                         = ssu_pkg::SSU_ZERO_BYTE;
      stat_word[ssu_pkg::SSU_STAT_DONE] = done;
      stat_word[ssu_pkg::SSU_STAT_COLL] = coll;
   end

   // Read data stand for the one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= ssu_pkg::SSU_ZERO_BYTE;
      end else if (rd) begin
         case (addr)
            ssu_pkg::SSU_ADDR_CTRL: begin
               rdata <= ctrl;
            end
            ssu_pkg::SSU_ADDR_STATUS: begin
               rdata <= stat_word;
            end
            ssu_pkg::SSU_ADDR_DATA: begin
               rdata <= shift_to_bus;
            end
            default: begin
               rdata <= ssu_pkg::SSU_ZERO_BYTE;
            end
         endcase
      end else begin
         rdata <= ssu_pkg::SSU_ZERO_BYTE;
      end
   end

   // Interrupt and stop-mode wake; wake is for slave operation only
   assign irq  = done && irq_en;
   assign wake = irq && stop_mode && enable && !master;

   // Port C takeover; direction bits have no say while enabled
   always_comb begin
      port_c_o  = port_c_out;
      port_c_oe = port_c_dir;
      if (enable) begin
         port_c_o[ssu_pkg::SSU_PIN_IN]   = 1'b0;
         port_c_oe[ssu_pkg::SSU_PIN_IN]  = 1'b0;
         port_c_o[ssu_pkg::SSU_PIN_OUT]  = out_bit;
         port_c_oe[ssu_pkg::SSU_PIN_OUT] = 1'b1;
         port_c_o[ssu_pkg::SSU_PIN_SCK]  = sck_out;
         port_c_oe[ssu_pkg::SSU_PIN_SCK] = master;
      end
   end
endmodule : ssu_serial_unit

// *** ssu_far_slave.sv ***
/* Far slave, MSB first. */
`timescale 1ns/1ps
module ssu_far_slave (input wire logic rst_n, sck, mosi, input wire logic [7:0] tx,
   output logic miso = 0, output logic [7:0] rx);
   logic [2:0] n = 3'h0;
   always @(negedge sck) miso <= tx[3'h7 - n];
   always @(posedge sck) if (rst_n) {rx, n} <= {rx[6:0], mosi, n + 3'h1};
endmodule : ssu_far_slave

// *** ssu_serial_unit_assertions.sv ***
/*
 * Pin and bus checker for the simple serial unit.
 * Assumes it is bound into the unit and sees only the unit's ports.
 */
`timescale 1ns/1ps
module ssu_chk (
   input wire logic       clk,        // Processor clock
   input wire logic       rst_n,      // Asynchronous reset, active low
   input wire logic       rd,         // Read strobe
   input wire logic [7:0] rdata,      // Read data
   input wire logic       stop_mode,  // Stop mode
   input wire logic       irq,        // Completion interrupt
   input wire logic       wake,       // Wake request
   input wire logic [2:0] port_c_o,   // Pin outputs
   input wire logic [2:0] port_c_oe   // Pin output enables
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Driven serial clock goes low
   sequence s_sck_fall;
      port_c_oe[2] && $fell(port_c_o[2]);
   endsequence
   // Serial clock stays high
   sequence s_hi;
      port_c_o[2] [*2];
   endsequence
   property p_idle; $rose(irq) && port_c_oe[2] |-> s_hi; endproperty
   a_idle: assert property (p_idle) else $error("clock low");
   property p_pins; port_c_oe[2] |-> port_c_oe[1]; endproperty
   a_pins: assert property (p_pins) else $error("out off");
   property p_wake; wake |-> stop_mode && irq && !port_c_oe[2]; endproperty
   a_wake: assert property (p_wake) else $error("wake outside slave stop");
   property p_rdata_quiet; !$past(rd) |-> rdata == 8'h00; endproperty
   a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside slot");
   property p_out_on_fall; $changed(port_c_o[1]) && port_c_oe[1] && port_c_oe[2] |-> s_sck_fall; endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("data moved off falling edge");
   property p_low_span; s_sck_fall |-> ##[1:8] port_c_o[2]; endproperty
   a_low_span: assert property (p_low_span) else $error("clock low too long");
endmodule : ssu_chk
bind ssu_serial_unit ssu_chk ssu_chk_inst (.*);

// *** simple_sync_serial_port_tb_top.sv ***
/* Bench, far slave. */
`timescale 1ns/1ps
module simple_sync_serial_port_tb_top;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, stop_mode = 0, miso, irq, wake, ext_sck = 1;
   logic [1:0] addr = 0;
   logic [7:0] wdata = 0, tx = 0, rdata, rx, v;
   logic [2:0] port_c_out = 3'h7, port_c_dir = 3'h6, port_c_o, port_c_oe;
   wire [2:0] port_c_in = {port_c_oe[2] ? port_c_o[2] : ext_sck, port_c_o[1], miso};
   int mismatches = 0, compares = 0;
   logic [39:0] t [2] = '{40'h7001966980, 40'hd1c30f0fc3};
   ssu_serial_unit ssu_serial_unit_inst (.*);
   ssu_far_slave ssu_far_slave_inst (.*, .sck(port_c_in[2]), .mosi(port_c_in[1]));
   initial forever #12.5 clk = ~clk;
   task automatic bus(logic w, logic [1:0] a, logic [7:0] d);
      @(posedge clk) {wr, rd, addr, wdata} <= {w, !w, a, d};
      @(posedge clk) {wr, rd} <= 2'b00;
      @(negedge clk) v = rdata;
   endtask : bus
   task automatic chk(string n, logic [7:0] e, s); compares++;
      if (s !== e) begin mismatches++; $display("wrong value %s exp %h got %h", n, e, s); end
   endtask : chk
   task automatic poll; v = 0; repeat (300) if (v[7] !== 1'b1) bus(0, 2'h1, 8'h00); endtask : poll
   task automatic close_out; if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors"); $finish; endtask : close_out
   initial begin #100us; mismatches++; close_out(); end
   initial begin repeat (20) @(posedge clk); rst_n <= 1;
      foreach (t[r]) begin bus(1, 2'h0, t[r][39:32]); tx <= t[r][23:16];
         bus(1, 2'h2, t[r][31:24]); poll();
         bus(0, 2'h2, 8'h00); chk("read", t[r][15:8], v);
         chk("sent", t[r][7:0], rx); end
      bus(1, 2'h2, 8'h5a); bus(1, 2'h2, 8'hff); poll(); chk("coll", 8'hc0, v);
      chk("kept", 8'h5a, rx); bus(0, 2'h2, 8'h00);
      bus(1, 2'h0, 8'hc0); tx <= 8'h3c; bus(1, 2'h2, 8'ha5); stop_mode <= 1;
      repeat (8) begin repeat (4) @(posedge clk); ext_sck <= 0; repeat (4) @(posedge clk); ext_sck <= 1; end
      repeat (4) @(posedge clk); @(negedge clk); chk("wake", 8'h01, wake); chk("slave sent", 8'ha5, rx);
      poll(); chk("slave stat", 8'h80, v); bus(0, 2'h2, 8'h00); chk("slave read", 8'h3c, v);
      @(negedge clk); chk("wake off", 8'h00, wake); close_out(); end
endmodule : simple_sync_serial_port_tb_top
